// ### tb/uotg_chk.sv
// Checker for the bus, flag and threshold ports of the OTG event block
`timescale 1ns/10ps
module uotg_chk #(
   parameter int MS_CYCLES = 20
)
(
   // Bus
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Pins and outputs
   input wire logic usb_id,
   input wire logic usb_dp,
   input wire logic usb_dm,
   input wire logic vbus_session_end,
   input wire logic vbus_session_valid,
   input wire logic [7:0] frame_start_threshold_value,
   input wire logic irq
);
   logic [7:0] seen_reg;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence rd_flags_s;
      pready && !pwrite && paddr == 8'h00;
   endsequence
   // Flags seen set; only a write of one may drop them
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         seen_reg <= 8'h00;
      else if (pready && paddr == 8'h00)
         seen_reg <= pwrite ? (seen_reg & ~pwdata[7:0]) : prdata[7:0];
   end
   a_ready_one: assert property (setup_s |=> pready) else $error("no ready");
   a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
   a_ready_access: assert property (pready |-> psel && penable) else $error("stray ready");
   a_flag_rsvd: assert property (rd_flags_s |-> prdata[31:8] == 0 && !prdata[1]) else $error("rsvd");
   a_flag_sticky: assert property (rd_flags_s |-> (prdata[7:0] & seen_reg) == seen_reg) else $error("lost");
   a_thr_upper: assert property (pready && paddr == 8'h08 |-> prdata[31:8] == 0) else $error("upper");
   a_thr_copy: assert property (pready && pwrite && paddr == 8'h08
      |-> ##2 frame_start_threshold_value == $past(pwdata[7:0], 2)) else $error("thr copy");
   a_thr_hold: assert property (!(pready && pwrite && paddr == 8'h08)
      |-> ##2 $stable(frame_start_threshold_value)) else $error("thr moved");
endmodule : uotg_chk
bind uotg_event_flags uotg_chk #(.MS_CYCLES(MS_CYCLES)) chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .usb_id(usb_id), .usb_dp(usb_dp), .usb_dm(usb_dm), .vbus_session_end(vbus_session_end),
   .vbus_session_valid(vbus_session_valid), .frame_start_threshold_value(frame_start_threshold_value), .irq(irq));

// ### tb/uotg_xcvr_model.sv
// Transceiver and comparator pin model for the OTG event block
`timescale 1ns/10ps
module uotg_xcvr_model
(
   // Clock, reset and flip requests
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [4:0] flip,
   // Pins: id, D+, D-, session end, session valid
   output logic [4:0] pins
);
   // Pins move on the pclk edge, so the block sees them as synchronous inputs, one edge later
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pins <= 5'h00;
      else
         pins <= pins ^ flip;
   end
endmodule : uotg_xcvr_model

// ### tb/usb_otg_event_flags_sof_threshold_bench.sv
// Self-checking bench for the OTG event flags and threshold block
`timescale 1ns/10ps
`define CHK(a, b, m) begin checks++; if ((a) !== (b)) begin err_total++; $display("MISMATCH %0t %s", $time, m); end end
module usb_otg_event_flags_sof_threshold_bench;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, irq, err;
   logic [7:0] thr_value;
   logic [7:0] seed = 8'h0d;
   logic [7:0] thr_q[$];
   logic [4:0] flip = 5'h00;
   logic [4:0] pins;
   logic [4:0] fl[6] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h02, 5'h01};
   int err_total = 0;
   int checks = 0;
   int exp;
   always #20 pclk = ~pclk;
   uotg_xcvr_model xcvr (.pclk(pclk), .presetn(presetn), .flip(flip), .pins(pins));
   uotg_event_flags #(.MS_CYCLES(20)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .usb_id(pins[4]), .usb_dp(pins[3]), .usb_dm(pins[2]), .vbus_session_end(pins[1]),
      .vbus_session_valid(pins[0]), .frame_start_threshold_value(thr_value), .irq(irq));
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr
   task automatic idle(input int n);
      repeat (n) @(posedge pclk);
   endtask : idle
   // One transfer; only the watchdog ends the wait on a silent slave
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic pulse(input logic [4:0] f);
      flip <= f;
      @(posedge pclk);
      flip <= 5'h00;
      idle(8);
   endtask : pulse
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : print_verdict
   // Watchdog at 10000 cycles, far beyond the few hundred cycles the tests need
   initial
   begin
      #400000;
      err_total++;
      $display("MISMATCH %0t watchdog", $time);
      print_verdict();
   end
   initial
   begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, 8'h08, 0);
      `CHK(rd, 32'h0, "thr reset")
      apb(0, 8'h00, 0);
      `CHK(rd[7:0] & 8'h9d, 8'h00, "flag reset")
      $display("test reset done");
      thr_q = '{8'h4a, 8'h2a, 8'h1a, 8'h12};
      repeat (4)
      begin
         seed = lfsr(seed);
         thr_q.push_back(seed);
      end
      foreach (thr_q[i])
      begin
         apb(1, 8'h08, {24'hffffff, thr_q[i]});
         apb(0, 8'h08, 0);
         `CHK(rd, {24'h0, thr_q[i]}, "thr read")
         `CHK(thr_value, thr_q[i], "thr out")
      end
      apb(0, 8'h10, 0);
      `CHK({err, rd}, 33'h100000000, "unmapped")
      $display("test threshold done");
      // Timer and line flags drift in on their own, so only bits 7,4,3,2,0 are compared
      for (int i = 0; i < 6; i++)
      begin
         apb(1, 8'h00, 32'hff);
         pulse(fl[i]);
         apb(1, 8'h00, 0);
         apb(0, 8'h00, 0);
         exp = 8'h10;
         if (fl[i][4]) exp |= 8'h80;
         if (fl[i][1]) exp |= (pins[1] ? 8'h0c : 8'h04);
         if (fl[i][0]) exp |= 8'h01;
         `CHK(rd[7:0] & 8'h9d, exp[7:0], "event flags")
         `CHK({rd[31:8], rd[1]}, 25'h0, "flag rsvd")
      end
      pulse(5'h08);
      apb(1, 8'h00, 32'hff);
      idle(30);
      apb(0, 8'h00, 0);
      `CHK(rd[5], 1'b1, "line stable")
      apb(0, 8'h0c, 0);
      `CHK(rd, {30'h0, pins[3], pins[2]}, "line state")
      apb(1, 8'h00, 32'hff);
      idle(50);
      apb(0, 8'h00, 0);
      `CHK(rd[6:5], 2'b10, "ms tick")
      $display("test events done");
      apb(1, 8'h04, 32'h80);
      apb(1, 8'h00, 32'hff);
      idle(2);
      `CHK(irq, 1'b0, "irq idle")
      pulse(5'h10);
      `CHK(irq, 1'b1, "irq set")
      apb(1, 8'h00, 32'h80);
      idle(2);
      `CHK(irq, 1'b0, "irq clear")
      apb(1, 8'h04, 32'h0);
      pulse(5'h10);
      `CHK(irq, 1'b0, "irq masked")
      $display("test irq done");
      print_verdict();
   end
endmodule : usb_otg_event_flags_sof_threshold_bench

// ### verilog/uotg_event_flags.sv
// OTG event flags, start-of-frame threshold and interrupt logic behind an APB slave
//
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/10ps
module uotg_event_flags #(
   parameter int MS_CYCLES = uotg_pkg::MS_CYCLES
)
(
   // APB clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Transceiver and comparator pins, asynchronous
   input wire logic usb_id,
   input wire logic usb_dp,
   input wire logic usb_dm,
   input wire logic vbus_session_end,
   input wire logic vbus_session_valid,
   // Threshold value towards the frame scheduler and interrupt
   output logic [7:0] frame_start_threshold_value,
   output logic irq
);

   // Both 1 ms counters are 24 bits wide and the line counter compares against MS_CYCLES - 2, so refuse other periods
   if (MS_CYCLES < 2 || MS_CYCLES > 16777215)
   begin : g_ms_cycles_check
      $error("uotg_event_flags: MS_CYCLES out of range");
   end

   // Pin order within the synchroniser vectors
   localparam int PIN_COUNT = 5;
   localparam int IDX_ID = 0;
   localparam int IDX_DP = 1;
   localparam int IDX_DM = 2;
   localparam int IDX_SEND = 3;
   localparam int IDX_SVALID = 4;

   // Pin synchronisation and change detection
   logic [PIN_COUNT-1:0] pin_raw;
   logic [PIN_COUNT-1:0] sync1_reg;
   logic [PIN_COUNT-1:0] sync2_reg;
   logic [PIN_COUNT-1:0] prev_reg;
   logic [PIN_COUNT-1:0] pin_change;
   // 1 ms timer and line state stability
   logic [23:0] ms_count_reg;
   logic ms_tick;
   logic [1:0] line_now;
   logic [1:0] line_last_reg;
   logic [1:0] line_stable_reg;
   logic [23:0] line_count_reg;
   logic line_stable_event;
   // Flag, mask and threshold registers
   logic [7:0] flags_reg;
   logic [7:0] mask_reg;
   logic [7:0] flags_set;
   logic [7:0] flags_clr;
   logic [7:0] threshold_reg;
   // Bus decode and read path
   logic wr_access;
   logic rd_access;
   logic addr_ok;
   logic [31:0] rdata_next;

   assign pin_raw = {vbus_session_valid, vbus_session_end, usb_dm, usb_dp, usb_id};

   // Two-stage synchronisers; only the second stage feeds logic
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end
      else
      begin
         sync1_reg <= pin_raw;
         sync2_reg <= sync1_reg;
      end
   end

   // Previous synchronised value for change detection
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prev_reg <= '0;
      end
      else
      begin
         prev_reg <= sync2_reg;
      end
   end

   // Reset zeros sit in both synchroniser stages and prev_reg for three edges; a pin that idles
   // high would look like a change without this guard
   logic [2:0] primed_reg;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         primed_reg <= 3'h0;
      end
      else
      begin
         primed_reg <= {primed_reg[1:0], 1'b1};
      end
   end

   // Change on any pin; suppressed until the history holds real pin values
   assign pin_change = primed_reg[2] ? (sync2_reg ^ prev_reg) : '0;

   // Free-running 1 ms timer
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ms_count_reg <= '0;
      end
      else if (ms_tick)
      begin
         ms_count_reg <= '0;
      end
      else
      begin
         ms_count_reg <= ms_count_reg + 24'h000001;
      end
   end

   // Wraps at exactly MS_CYCLES, so the period does not drift
   assign ms_tick = (ms_count_reg == 24'(MS_CYCLES - 1));

   // Line state stability: restart the count on every change of D+/D-
   assign line_now = {sync2_reg[IDX_DP], sync2_reg[IDX_DM]};

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         line_last_reg <= '0;
         line_count_reg <= '0;
         line_stable_reg <= '0;
      end
      else
      begin
         line_last_reg <= line_now;
         if (line_now != line_last_reg)
         begin
            line_count_reg <= '0;
         end
         else if (line_count_reg != 24'(MS_CYCLES - 1))
         begin
            line_count_reg <= line_count_reg + 24'h000001;
         end
         if (line_stable_event)
         begin
            line_stable_reg <= line_last_reg;
         end
      end
   end

   // Fires once, the cycle the count reaches 1 ms, only if the state differs from the recorded one
   assign line_stable_event = (line_now == line_last_reg) &&
                              (line_count_reg == 24'(MS_CYCLES - 2)) &&
                              (line_last_reg != line_stable_reg);

   // Hardware set sources
   always_comb
   begin
      flags_set = '0;
      flags_set[uotg_pkg::ID_CHANGE_BIT] = pin_change[IDX_ID];
      flags_set[uotg_pkg::MS_TIMER_BIT] = ms_tick;
      flags_set[uotg_pkg::LINE_STABLE_BIT] = line_stable_event;
      flags_set[uotg_pkg::BUS_ACTIVITY_BIT] = |pin_change;
      // Rising edge of the session end level means VBUS dropped below session end
      flags_set[uotg_pkg::SESSION_VALID_CHANGE_BIT] = pin_change[IDX_SEND] & sync2_reg[IDX_SEND];
      flags_set[uotg_pkg::B_VBUS_CHANGE_BIT] = pin_change[IDX_SEND];
      flags_set[uotg_pkg::A_VBUS_CHANGE_BIT] = pin_change[IDX_SVALID];
   end

   // APB decode; zero wait states
   assign wr_access = psel && penable && pwrite;
   assign rd_access = psel && !penable && !pwrite;
   assign addr_ok = (paddr == uotg_pkg::EVENT_FLAGS_OFFSET) || (paddr == uotg_pkg::EVENT_MASK_OFFSET) ||
                    (paddr == uotg_pkg::THRESHOLD_OFFSET) || (paddr == uotg_pkg::LINE_STATE_OFFSET);

   assign flags_clr = (wr_access && paddr == uotg_pkg::EVENT_FLAGS_OFFSET) ?
                      pwdata[7:0] : 8'h00;

   // Sticky flags, one flop per bit; a hardware set beats a write-one clear in the same cycle,
   // so an event that lands during the clear is never lost
   for (genvar b = 0; b < $bits(flags_reg); b++)
   begin : g_flag
      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
         begin
            flags_reg[b] <= uotg_pkg::FLAGS_RESET[b];
         end
         else if (!uotg_pkg::FLAG_IMPL_MASK[b])
         begin
            flags_reg[b] <= 1'b0;
         end
         else if (flags_set[b])
         begin
            flags_reg[b] <= 1'b1;
         end
         else if (flags_clr[b])
         begin
            flags_reg[b] <= 1'b0;
         end
      end
   end

   // Mask and threshold registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mask_reg <= 8'h00;
         threshold_reg <= uotg_pkg::THRESHOLD_RESET;
      end
      else if (wr_access)
      begin
         if (paddr == uotg_pkg::EVENT_MASK_OFFSET)
         begin
            mask_reg <= pwdata[7:0] & uotg_pkg::FLAG_IMPL_MASK;
         end
         if (paddr == uotg_pkg::THRESHOLD_OFFSET)
         begin
            threshold_reg <= pwdata[7:0];
         end
      end
   end

   // Read mux; unused bits stay zero
   always_comb
   begin
      rdata_next = 32'h00000000;
      unique case (paddr)
         uotg_pkg::EVENT_FLAGS_OFFSET: rdata_next[7:0] = flags_reg;
         uotg_pkg::EVENT_MASK_OFFSET: rdata_next[7:0] = mask_reg;
         uotg_pkg::THRESHOLD_OFFSET: rdata_next[7:0] = threshold_reg;
         uotg_pkg::LINE_STATE_OFFSET: rdata_next[1:0] = line_stable_reg;
         default: rdata_next = 32'h00000000;
      endcase
   end

   // Read data captured in the setup cycle so it stands registered in the access phase
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
         pready <= 1'b0;
      end
      else
      begin
         if (rd_access)
         begin
            prdata <= rdata_next;
         end
         pslverr <= psel && !penable && !addr_ok; // Unmapped address answers with an error
         pready <= psel && !penable;
      end
   end

   // Registered outputs toward the rest of the port
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         frame_start_threshold_value <= uotg_pkg::THRESHOLD_RESET;
         irq <= 1'b0;
      end
      else
      begin
         frame_start_threshold_value <= threshold_reg;
         irq <= |(flags_reg & mask_reg); // Lags the flags by one cycle
      end
   end

endmodule : uotg_event_flags

// ### verilog/uotg_pkg.sv
// Package: register map, field positions and timing constants of the OTG event block
package uotg_pkg;
   // Register byte offsets
   localparam logic [7:0] EVENT_FLAGS_OFFSET = 8'h00;
   localparam logic [7:0] EVENT_MASK_OFFSET = 8'h04;
   localparam logic [7:0] THRESHOLD_OFFSET = 8'h08;
   localparam logic [7:0] LINE_STATE_OFFSET = 8'h0c;
   // Event flag bit positions
   localparam int ID_CHANGE_BIT = 7;
   localparam int MS_TIMER_BIT = 6;
   localparam int LINE_STABLE_BIT = 5;
   localparam int BUS_ACTIVITY_BIT = 4;
   localparam int SESSION_VALID_CHANGE_BIT = 3;
   localparam int B_VBUS_CHANGE_BIT = 2;
   localparam int A_VBUS_CHANGE_BIT = 0;
   // Implemented flag bits; bit 1 and bits 31..8 read zero
   localparam logic [7:0] FLAG_IMPL_MASK = 8'hfd;
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   localparam logic [7:0] THRESHOLD_RESET = 8'h00;
   // Timing
   localparam int CLK_HZ = 25000000;
   localparam int MS_TIME_US = 1000;
   localparam int MS_CYCLES = (CLK_HZ / 1000000) * MS_TIME_US;
endpackage : uotg_pkg
